// ==== pkg/gpf_pkg.sv ====
// shared constants and carrier types for the pin-function block
// assumes one device clock domain; register values arrive as plain ports
package gpf_pkg;

   // register offsets of the pin control registers in the mac map
   localparam logic [7:0] GPF_DIR_OFFSET   = 8'h1E;  // direction register
   localparam logic [7:0] GPF_LEVEL_OFFSET = 8'h1F;  // level register
   localparam logic [7:0] GPF_REG_RESET    = 8'h00;  // general pins one to three inputs, levels low

   // field positions inside the registers; output-only pins have bits in the level register only
   localparam int GPF_GP_FIRST   = 1;   // general pin one sits at bit 1
   localparam int GPF_GP_COUNT   = 3;   // general pins one to three
   localparam int GPF_OUT_FIRST  = 4;   // output-only pins start at bit 4
   localparam int GPF_OUT_COUNT  = 3;   // output-only pins four to six
   localparam int GPF_REG_WIDTH  = 8;
   localparam int GPF_HI_WIDTH   = 8;   // upper data byte width

   // strap level that selects the narrow host bus
   localparam logic            GPF_STRAP_WIDE8 = 1'b1;
   // cycles after reset release before the strap synchroniser is full
   localparam logic [2:0]      GPF_STRAP_SETTLE = 3'h4;

   // led mode encoding
   typedef enum logic {GPF_LED_CARRIER, GPF_LED_LINK_CARRIER} gpf_led_mode_type;

   // phy status bundle, same clock as this block
   typedef struct packed
   {
      logic link;      // link up
      logic crs;       // carrier sense
      logic speed100;  // phy runs at 100 mbit/s
   } gpf_phy_type;

   // driver side of the three general pins
   typedef struct packed
   {
      logic [GPF_GP_COUNT-1:0] o;   // output level
      logic [GPF_GP_COUNT-1:0] oe;  // high while the pin is driven
   } gpf_gp_drive_type;

endpackage

// ==== design/gpf_sync.sv ====
// three-stage input synchroniser with agreement filter
// assumes d_i is asynchronous to clk; the filtered output moves only when stages two and three agree
`timescale 1ns/1ps
module gpf_sync #(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // synchroniser chain; s1_r is read by s2_r only
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // accept a new level once two stages agree
   always_ff @(posedge clk)
   begin
      if (!rstn)
         q_o <= '0;
      else
      begin
         for (int i = 0; i < W; i++)
         begin
            if (s2_r[i] == s3_r[i])
               q_o[i] <= s3_r[i];
         end
      end
   end

endmodule

// ==== design/gpf_pins.sv ====
// pin-function logic: led indicators, general pins, upper data byte, eeprom data line, width strap
// assumes phy status and register values come from logic on CLK; pins are split into i/o/oe
`timescale 1ns/1ps

//Contract
//- led mode one: activity led shows link combined with carrier sense.
//- led mode zero: activity led shows carrier sense only.
//- speed led driven low while phy runs at 100 mbit/s.
//- speed led left floating while phy runs at 10 mbit/s.
//- general pins one and two are tri-state, inputs after reset.
//- pins one and two follow bits 1 and 2 of registers 1Eh and 1Fh.
//- serial variant: pin two tied to serial data in, its controls ignored.
//- pin three input after reset, controlled by bit 3 of 1Eh and 1Fh.
//- upper data byte is host bus in 16-bit mode, general i/o in 8-bit.
//- in 8-bit mode pins four to six are outputs set from 1Fh.
//- eeprom data line bidirectional, held low when no transfer runs.
//- width strap sampled at reset: high selects 8-bit, else 16-bit.
module gpf_pins (
   input  wire logic                         CLK,
   input  wire logic                         RSTN,
   input  wire gpf_pkg::gpf_led_mode_type    LED_MODE,
   input  wire gpf_pkg::gpf_phy_type         PHY,
   input  wire logic                         SERIAL_VARIANT,
   input  wire logic [7:0]                   DIR_REG,
   input  wire logic [7:0]                   LEVEL_REG,
   output logic      [7:0]                   LEVEL_READ,
   output logic                              ACTIVITY_INDICATOR,
   output logic                              SPEED_INDICATOR_O,
   output logic                              SPEED_INDICATOR_OE,
   input  wire logic [2:0]                   GENERAL_PIN_I,
   output gpf_pkg::gpf_gp_drive_type         GENERAL_PIN_DRIVE,
   output logic      [2:0]                   OUTPUT_ONLY_PINS,
   output logic                              OUTPUT_ONLY_OE,
   input  wire logic                         BUS_WIDTH_STRAP,
   output logic                              WIDTH_8BIT,
   output logic                              WIDTH_VALID,
   input  wire logic [7:0]                   UPPER_DATA_BYTE_I,
   output logic      [7:0]                   UPPER_DATA_BYTE_O,
   output logic      [7:0]                   UPPER_DATA_BYTE_OE,
   output logic      [7:0]                   UPPER_BYTE_IN,
   input  wire logic [7:0]                   HOST_HI_O,
   input  wire logic                         HOST_HI_OE,
   input  wire logic [7:0]                   APP_HI_O,
   input  wire logic [7:0]                   APP_HI_OE,
   input  wire logic                         EE_XFER_ACTIVE,
   input  wire logic                         EE_DATA_O,
   input  wire logic                         EE_DATA_OE,
   output logic                              EE_DATA_IN,
   input  wire logic                         EEPROM_DATA_LINE_I,
   output logic                              EEPROM_DATA_LINE_O,
   output logic                              EEPROM_DATA_LINE_OE
);

   localparam int GF = gpf_pkg::GPF_GP_FIRST;
   localparam int OF = gpf_pkg::GPF_OUT_FIRST;
   localparam int GN = gpf_pkg::GPF_GP_COUNT;
   localparam int ON = gpf_pkg::GPF_OUT_COUNT;

   logic [GN-1:0] gp_sync;
   logic          strap_sync;
   logic [GN-1:0] gp_o_nxt;
   logic [GN-1:0] gp_oe_nxt;
   logic [7:0]    read_nxt;
   logic          act_nxt;
   logic [2:0]    settle_r;
   logic          wide8_r;
   logic          valid_r;

   // pin and strap synchronisers
   gpf_sync #(.W(GN + 1)) u_sync (
      .clk  (CLK),
      .rstn (RSTN),
      .d_i  ({BUS_WIDTH_STRAP, GENERAL_PIN_I}),
      .q_o  ({strap_sync, gp_sync})
   );

   // activity indicator source, low lights the led
   always_comb
   begin
      case (LED_MODE)
         gpf_pkg::GPF_LED_LINK_CARRIER: act_nxt = ~PHY.link | PHY.crs;
         gpf_pkg::GPF_LED_CARRIER:      act_nxt = ~PHY.crs;
         default:                       act_nxt = 1'b1;
      endcase
   end

   // indicator outputs
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         ACTIVITY_INDICATOR <= 1'b1;
         SPEED_INDICATOR_O  <= 1'b0;
         SPEED_INDICATOR_OE <= 1'b0;
      end
      else
      begin
         ACTIVITY_INDICATOR <= act_nxt;
         SPEED_INDICATOR_O  <= 1'b0;
         SPEED_INDICATOR_OE <= PHY.speed100;
      end
   end

   // per-pin direction and level decode for general pins one to three
   genvar g;
   generate
      for (g = 0; g < GN; g++)
      begin : g_pin
         // pin two loses its controls in the serial variant
         if (g == 1)
         begin : g_two
            assign gp_oe_nxt[g] = DIR_REG[GF + g] & ~SERIAL_VARIANT;
         end
         else
         begin : g_other
            assign gp_oe_nxt[g] = DIR_REG[GF + g];
         end
         assign gp_o_nxt[g] = LEVEL_REG[GF + g] & gp_oe_nxt[g];
      end
   endgenerate

   // general pin drivers, inputs out of reset
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         GENERAL_PIN_DRIVE.o  <= '0;
         GENERAL_PIN_DRIVE.oe <= '0;
      end
      else
      begin
         GENERAL_PIN_DRIVE.o  <= gp_o_nxt;
         GENERAL_PIN_DRIVE.oe <= gp_oe_nxt;
      end
   end

   // level read-back: driven pins return their level bit, inputs the synced pin
   always_comb
   begin
      read_nxt = gpf_pkg::GPF_REG_RESET;
      for (int i = 0; i < GN; i++)
         read_nxt[GF + i] = gp_oe_nxt[i] ? LEVEL_REG[GF + i] : gp_sync[i];
      for (int i = 0; i < ON; i++)
         read_nxt[OF + i] = LEVEL_REG[OF + i];
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         LEVEL_READ <= gpf_pkg::GPF_REG_RESET;
      else
         LEVEL_READ <= read_nxt;
   end

   // strap capture once the synchroniser has filled after reset
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         settle_r <= '0;
         wide8_r  <= 1'b0;
         valid_r  <= 1'b0;
      end
      else if (!valid_r)
      begin
         if (settle_r == gpf_pkg::GPF_STRAP_SETTLE)
         begin
            wide8_r <= (strap_sync == gpf_pkg::GPF_STRAP_WIDE8);
            valid_r <= 1'b1;
         end
         else
            settle_r <= settle_r + 3'h1;
      end
   end

   assign WIDTH_8BIT  = wide8_r;
   assign WIDTH_VALID = valid_r;

   // upper data byte and output-only pins, steered by bus width
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         UPPER_DATA_BYTE_O  <= '0;
         UPPER_DATA_BYTE_OE <= '0;
         OUTPUT_ONLY_PINS   <= '0;
         OUTPUT_ONLY_OE     <= 1'b0;
      end
      else if (wide8_r)
      begin
         UPPER_DATA_BYTE_O  <= APP_HI_O;
         UPPER_DATA_BYTE_OE <= APP_HI_OE;
         OUTPUT_ONLY_PINS   <= LEVEL_REG[OF +: ON];
         OUTPUT_ONLY_OE     <= 1'b1;
      end
      else
      begin
         UPPER_DATA_BYTE_O  <= HOST_HI_O;
         UPPER_DATA_BYTE_OE <= {gpf_pkg::GPF_HI_WIDTH{HOST_HI_OE}};
         OUTPUT_ONLY_PINS   <= '0;
         OUTPUT_ONLY_OE     <= 1'b0;
      end
   end

   // eeprom data line: engine drives during a transfer, low otherwise
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         EEPROM_DATA_LINE_O  <= 1'b0;
         EEPROM_DATA_LINE_OE <= 1'b1;
      end
      else if (EE_XFER_ACTIVE)
      begin
         EEPROM_DATA_LINE_O  <= EE_DATA_O;
         EEPROM_DATA_LINE_OE <= EE_DATA_OE;
      end
      else
      begin
         EEPROM_DATA_LINE_O  <= 1'b0;
         EEPROM_DATA_LINE_OE <= 1'b1;
      end
   end

   // registered pin inputs for the host bus and eeprom engine
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         UPPER_BYTE_IN <= '0;
         EE_DATA_IN    <= 1'b0;
      end
      else
      begin
         UPPER_BYTE_IN <= UPPER_DATA_BYTE_I;
         EE_DATA_IN    <= EEPROM_DATA_LINE_I;
      end
   end

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_act_link_mode: assert property (
      (LED_MODE == gpf_pkg::GPF_LED_LINK_CARRIER && PHY.link && !PHY.crs) |=> !ACTIVITY_INDICATOR)
      else $error("activity led not lit with link and no carrier in mode one");

   a_act_carrier_mode: assert property (
      (LED_MODE == gpf_pkg::GPF_LED_CARRIER && !PHY.link && PHY.crs) |=> !ACTIVITY_INDICATOR)
      else $error("activity led ignores carrier in mode zero");

   a_speed_fast: assert property (
      PHY.speed100 |=> (SPEED_INDICATOR_OE && !SPEED_INDICATOR_O))
      else $error("speed led not driven low at 100 mbit/s");

   a_speed_slow: assert property (
      !PHY.speed100 |=> !SPEED_INDICATOR_OE)
      else $error("speed led driven at 10 mbit/s");

   // watched through reset itself, so the default disable must not apply here
   a_gp_reset_input: assert property (@(posedge CLK) disable iff (1'b0)
      !RSTN |=> (GENERAL_PIN_DRIVE.oe == '0))
      else $error("general pin driven after reset");

   a_gp_one_drive: assert property (
      DIR_REG[GF] |=> (GENERAL_PIN_DRIVE.oe[0] && GENERAL_PIN_DRIVE.o[0] == $past(LEVEL_REG[GF])))
      else $error("pin one does not follow its level bit");

   a_serial_block: assert property (
      SERIAL_VARIANT |=> !GENERAL_PIN_DRIVE.oe[1])
      else $error("pin two driven in serial variant");

   a_gp_three_input: assert property (
      !DIR_REG[GF + 2] |=> !GENERAL_PIN_DRIVE.oe[2])
      else $error("pin three driven while set as input");

   a_upper_host: assert property (
      !wide8_r |=> (UPPER_DATA_BYTE_OE == {8{$past(HOST_HI_OE)}}))
      else $error("upper byte not on host bus in 16-bit mode");

   a_out_only: assert property (
      wide8_r |=> (OUTPUT_ONLY_OE && OUTPUT_ONLY_PINS == $past(LEVEL_REG[OF +: ON])))
      else $error("output-only pins do not follow level register");

   a_ee_idle_low: assert property (
      !EE_XFER_ACTIVE |=> (EEPROM_DATA_LINE_OE && !EEPROM_DATA_LINE_O))
      else $error("eeprom line not low when idle");

   a_strap_capture: assert property (
      $rose(valid_r) |-> (wide8_r == $past(strap_sync)))
      else $error("bus width does not match the strap");

   a_read_sync: assert property (
      (!DIR_REG[GF] && GENERAL_PIN_I[0])[*7] |-> LEVEL_READ[GF])
      else $error("pin one input level not read back");

   c_link_lit:  cover property (LED_MODE == gpf_pkg::GPF_LED_LINK_CARRIER && !ACTIVITY_INDICATOR);
   c_speed100:  cover property (SPEED_INDICATOR_OE);
   c_gp_output: cover property (GENERAL_PIN_DRIVE.oe[2]);
   c_wide8:     cover property ($rose(valid_r) && wide8_r);

endmodule

// ==== verification/gpf_board.sv ====
// board model: pull-downs and external drivers on the general pins and the eeprom data line
// assumes drive and enable pairs from the pin block; the wire level is resolved here
`timescale 1ns/1ps
module gpf_board (
   input  wire gpf_pkg::gpf_gp_drive_type gp_drive,
   input  wire logic [2:0]                ext_en,
   input  wire logic [2:0]                ext_val,
   input  wire logic                      ee_o,
   input  wire logic                      ee_oe,
   input  wire logic                      ee_ext_en,
   input  wire logic                      ee_ext,
   output logic      [2:0]                gp_level,
   output logic                           ee_level
);
   // device driver first, then the external driver, else the pull-down
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         gp_level[i] = gp_drive.oe[i] ? gp_drive.o[i] : (ext_en[i] & ext_val[i]);
      ee_level = ee_oe ? ee_o : (ee_ext_en & ee_ext);
   end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the pin-function block, a board model on its far side
// assumes a 40 MHz clock; random stimulus comes from one fixed seed
`timescale 1ns/1ps
module testbench;
   logic                          clk, rstn, serial, strap, act, spd_o, spd_oe, oo_oe, w8, wv;
   logic                          hh_oe, ee_act, ee_o, ee_oe, ee_in, eel_o, eel_oe, eel_i;
   logic                          ee_xen, ee_x, ln, pe_o, pe_oe;
   gpf_pkg::gpf_led_mode_type     led_mode;
   gpf_pkg::gpf_phy_type          phy;
   gpf_pkg::gpf_gp_drive_type     gp_drv;
   logic [7:0]                    dir_reg, lvl_reg, lvl_rd, hh_o, app_o, app_oe, ub_i, ub_o, ub_oe, ub_in;
   logic [7:0]                    erd, msk;
   logic [2:0]                    gp_lvl, oo_pins, ext_en, ext_val, eoe;
   int                            err_total, tests_run;

   gpf_pins dut_u (.CLK(clk), .RSTN(rstn), .LED_MODE(led_mode), .PHY(phy), .SERIAL_VARIANT(serial),
      .DIR_REG(dir_reg), .LEVEL_REG(lvl_reg), .LEVEL_READ(lvl_rd), .ACTIVITY_INDICATOR(act),
      .SPEED_INDICATOR_O(spd_o), .SPEED_INDICATOR_OE(spd_oe), .GENERAL_PIN_I(gp_lvl),
      .GENERAL_PIN_DRIVE(gp_drv), .OUTPUT_ONLY_PINS(oo_pins), .OUTPUT_ONLY_OE(oo_oe),
      .BUS_WIDTH_STRAP(strap), .WIDTH_8BIT(w8), .WIDTH_VALID(wv), .UPPER_DATA_BYTE_I(ub_i),
      .UPPER_DATA_BYTE_O(ub_o), .UPPER_DATA_BYTE_OE(ub_oe), .UPPER_BYTE_IN(ub_in), .HOST_HI_O(hh_o),
      .HOST_HI_OE(hh_oe), .APP_HI_O(app_o), .APP_HI_OE(app_oe), .EE_XFER_ACTIVE(ee_act),
      .EE_DATA_O(ee_o), .EE_DATA_OE(ee_oe), .EE_DATA_IN(ee_in), .EEPROM_DATA_LINE_I(eel_i),
      .EEPROM_DATA_LINE_O(eel_o), .EEPROM_DATA_LINE_OE(eel_oe));

   gpf_board board_u (.gp_drive(gp_drv), .ext_en(ext_en), .ext_val(ext_val), .ee_o(eel_o),
      .ee_oe(eel_oe), .ee_ext_en(ee_xen), .ee_ext(ee_x), .gp_level(gp_lvl), .ee_level(eel_i));

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // compare one value, count and report
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // print counts and verdict, then stop
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // random inputs; pin-side values and direction held for 20-cycle segments
   task automatic drive(input int k);
      led_mode = gpf_pkg::gpf_led_mode_type'(1'($urandom));
      phy = 3'($urandom);
      lvl_reg = 8'($urandom);
      {hh_o, hh_oe, app_o, app_oe, ub_i} = 33'({$urandom, $urandom});
      {ee_act, ee_o, ee_oe} = 3'($urandom);
      if (k % 20 == 0)
      begin
         dir_reg = 8'($urandom);
         serial = 1'($urandom);
         {ext_en, ext_val, ee_xen, ee_x} = 8'($urandom);
      end
   endtask

   // hang guard
   initial
   begin
      #100000;
      err_total++;
      final_report();
   end

   // main sequence: one run per strap level
   initial
   begin
      err_total = 0;
      tests_run = 0;
      rstn = 1'b0;
      strap = 1'b0;
      void'($urandom(32'h1284_3bb2));
      drive(0);
      for (int r = 0; r < 2; r++)
      begin
         strap = r[0];
         rstn = 1'b0;
         repeat (10) @(posedge clk);
         #1;
         check({act, spd_oe, gp_drv.oe, eel_o, eel_oe, wv}, 8'h82);
         rstn = 1'b1;
         repeat (8) @(posedge clk);
         #1;
         check({wv, w8}, {1'b1, strap});
         // line level left by the inputs that have stood since reset release
         pe_o = ee_act & ee_o;
         pe_oe = ee_act ? ee_oe : 1'b1;
         for (int k = 0; k < 400; k++)
         begin
            drive(k);
            ln = pe_oe ? pe_o : (ee_xen & ee_x);
            @(posedge clk);
            #1;
            eoe = dir_reg[3:1] & ~{1'b0, serial, 1'b0};
            erd = {1'b0, lvl_reg[6:4], (eoe & lvl_reg[3:1]) | (~eoe & ext_en & ext_val), 1'b0};
            msk = (k % 20 >= 8) ? 8'hFF : 8'hF1;
            check(act, 1'(led_mode ? (~phy.link | phy.crs) : ~phy.crs));
            check({spd_o, spd_oe}, {1'b0, phy.speed100});
            check(gp_drv.oe, eoe);
            check(gp_drv.o & eoe, lvl_reg[3:1] & eoe);
            check({oo_oe, oo_pins}, r ? {1'b1, lvl_reg[6:4]} : 4'h0);
            check(ub_oe, r ? app_oe : {8{hh_oe}});
            check(ub_o, r ? app_o : hh_o);
            check(ub_in, ub_i);
            check({eel_o, eel_oe}, ee_act ? {ee_o, ee_oe} : 2'b01);
            check(ee_in, ln);
            check(lvl_rd & msk, erd & msk);
            pe_o = ee_act & ee_o;
            pe_oe = ee_act ? ee_oe : 1'b1;
         end
      end
      final_report();
   end
endmodule
